/* File: shared/home_return_map.vh */
`ifndef HOME_RETURN_MAP_VH
`define HOME_RETURN_MAP_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL        8'h00
`define REG_METHOD      8'h04
`define REG_STATUS      8'h08
`define REG_IRQ_STAT    8'h0C
`define REG_IRQ_MASK    8'h10
`define REG_CUR_POS     8'h14
`define REG_DISP_POS    8'h18
`define REG_OFFSET      8'h1C
`define REG_ALLOC       8'h20
`define REG_FLAGS       8'h40
// ----------------------------------------
// Method codes
// ----------------------------------------
`define METH_DOG1       4'h0
`define METH_DOG2       4'h1
`define METH_LIMIT2     4'h2
`define METH_HIGHSPEED  4'h3
`define METH_ABS_SET    4'h4
`define METH_DATA_SET   4'h5
// ----------------------------------------
// Amplifier input allocation words
// ----------------------------------------
`define ALLOC_A_IN1     32'h0032_3232
`define ALLOC_A_IN2     32'h0081_8181
`define ALLOC_A_IN3     32'h0082_8282
`define ALLOC_A_IN4     32'h002E_2E2E
`define ALLOC_A_IN5     32'h0022_2222
`define ALLOC_A_IN6     32'h0021_2121
`define ALLOC_A_IN7     32'h002B_2B2B
`define ALLOC_A_IN8     32'h0031_3131
`define ALLOC_B_IN2     32'h0000_0000
`define ALLOC_B_IN6     32'h0001_0101
`define ALLOC_B_IN7     32'h0002_0202
// ----------------------------------------
// Error code and field positions
// ----------------------------------------
`define ERR_LATCH_ALLOC 16'h0821
`define ERR_NOT_ALLOWED 16'h0822
`define CTRL_START_BIT  0
`define CTRL_DEVCLR_BIT 1
`define CTRL_ABSENC_BIT 2
`define CTRL_NEWAMP_BIT 3
`define CTRL_DIR_BIT    4
`define IRQ_DONE_BIT    0
`define IRQ_ERR_BIT     1
`define IRQ_REV_BIT     2
`define IRQ_W           3
`endif

/* File: logic/axis_motion.v */
`default_nettype none
`include "home_return_map.vh"
// ----------------------------------------
// Simple axis mover toward a target
// ----------------------------------------
module axis_motion #(
   parameter POS_W = 32
) (
   // Clock and reset
   input  wire             i_sys_clk,
   input  wire             i_srst,
   // Command
   input  wire             i_go,
   input  wire [POS_W-1:0] i_target,
   input  wire             i_seek,
   input  wire             i_seek_fwd,
   input  wire             i_abort,
   // Feedback
   input  wire [POS_W-1:0] i_pos,
   // Status
   output reg              o_moving,
   output reg              o_fwd,
   output reg              o_arrived
);
   reg             seek_r;
   reg [POS_W-1:0] target_r;
   always @(posedge i_sys_clk)
   begin
      o_arrived <= 1'b0;
      if (i_srst)
      begin
         o_moving <= 1'b0;
         o_fwd    <= 1'b0;
         seek_r   <= 1'b0;
         target_r <= {POS_W{1'b0}};
      end
      else if (i_go)
      begin
         o_moving <= 1'b1;
         seek_r   <= i_seek;
         target_r <= i_target;
         o_fwd    <= i_seek ? i_seek_fwd : ($signed(i_target) > $signed(i_pos));
      end
      else if (o_moving)
      begin
         if (i_abort)
         begin
            o_moving  <= 1'b0;
            o_arrived <= 1'b1;
         end
         else if (!seek_r && i_pos == target_r)
         begin
            o_moving  <= 1'b0;
            o_arrived <= 1'b1;
         end
         else if (!seek_r)
            o_fwd <= ($signed(target_r) > $signed(i_pos));
      end
   end
endmodule
`default_nettype wire

/* File: logic/home_return_sequencer.v */
`default_nettype none
`include "home_return_map.vh"
module home_return_sequencer #(
   parameter POS_W = 32
) (
   // Clock and reset
   input  wire             i_sys_clk,
   input  wire             i_srst,
   // Avalon-MM slave
   input  wire [7:0]       i_avs_address,
   input  wire             i_avs_read,
   input  wire             i_avs_write,
   input  wire [31:0]      i_avs_writedata,
   output reg  [31:0]      o_avs_readdata,
   output wire             o_avs_waitrequest,
   // Axis 1 contacts from the control unit
   input  wire             i_axis1_home_start_request,
   input  wire             i_axis1_servo_on_request,
   input  wire             i_axis1_servo_off_request,
   output reg              o_axis1_busy_contact,
   output reg              o_axis1_home_done_contact,
   output reg              o_axis1_servo_locked_contact,
   output reg              o_error_notify_contact,
   // Amplifier side
   input  wire [POS_W-1:0] i_amp_position,
   input  wire             i_positive_overtravel_limit,
   input  wire             i_negative_overtravel_limit,
   input  wire             i_near_home_sensor,
   output reg              o_amp_zero_position,
   output reg              o_deviation_clear,
   output wire             o_move_active,
   output wire             o_move_fwd,
   // Interrupt
   output wire             o_irq
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   reg [5:0] sync1_r;
   reg [5:0] sync2_r;
   always @(posedge i_sys_clk)
   begin
      sync1_r <= {i_axis1_home_start_request, i_axis1_servo_on_request,
                  i_axis1_servo_off_request, i_positive_overtravel_limit,
                  i_negative_overtravel_limit, i_near_home_sensor};
      sync2_r <= sync1_r;
   end
   wire start_s  = sync2_r[5];
   wire son_s    = sync2_r[4];
   wire soff_s   = sync2_r[3];
   wire plim_s   = sync2_r[2];
   wire nlim_s   = sync2_r[1];
   wire home_s   = sync2_r[0];
   reg  start_d_r;
   wire start_pulse = start_s & ~start_d_r;
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [4:0]       ctrl_r;
   reg [3:0]       method_r;
   reg [31:0]      alloc_r [0:7];
   reg [POS_W-1:0] offset_r;
   reg [15:0]      err_code_r;
   reg [`IRQ_W-1:0] irq_stat_r;
   reg [`IRQ_W-1:0] irq_mask_r;
   reg              rd_ack_r;
   wire wr = i_avs_write;
   wire [2:0] alloc_idx = i_avs_address[4:2];
   wire alloc_hit = (i_avs_address[7:5] == 3'b001) || (i_avs_address[7:5] == 3'b010);
   assign o_avs_waitrequest = i_avs_read & ~rd_ack_r;
   assign o_irq = |(irq_stat_r & irq_mask_r);
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_MOVE = 4'b0010;
   localparam [3:0] ST_SET  = 4'b0100;
   localparam [3:0] ST_DONE = 4'b1000;
   reg [3:0] state_r;
   reg       go_r;
   reg       seek_r;
   reg       seek_fwd_r;
   reg       abort_r;
   wire      moving;
   wire      arrived;
   wire [POS_W-1:0] disp_pos = i_amp_position - offset_r;
   // Default allocation present when inputs 2 and 6 hold factory words
   wire alloc_default = (alloc_r[1] == `ALLOC_A_IN2) && (alloc_r[5] == `ALLOC_A_IN6);
   wire meth_second = (method_r == `METH_DOG2) || (method_r == `METH_LIMIT2);
   wire abs_only = ctrl_r[`CTRL_ABSENC_BIT] & ~ctrl_r[`CTRL_NEWAMP_BIT];
   wire meth_abs = (method_r == `METH_HIGHSPEED) || (method_r == `METH_ABS_SET);
   axis_motion #(
      .POS_W      (POS_W)
   ) u_motion (
      .i_sys_clk  (i_sys_clk),
      .i_srst     (i_srst),
      .i_go       (go_r),
      .i_target   (offset_r),  // Position 0 of display frame
      .i_seek     (seek_r),
      .i_seek_fwd (seek_fwd_r),
      .i_abort    (abort_r),
      .i_pos      (i_amp_position),
      .o_moving   (moving),
      .o_fwd      (o_move_fwd),
      .o_arrived  (arrived)
   );
   assign o_move_active = moving;
   // Limit on travel side while seeking: reverse
   wire lim_hit = moving & seek_r & ((o_move_fwd & plim_s) | (~o_move_fwd & nlim_s));
   // ----------------------------------------
   // Interrupt events
   // ----------------------------------------
   wire start_any = start_pulse ||
                    (wr && i_avs_address == `REG_CTRL && i_avs_writedata[`CTRL_START_BIT]);
   wire start_bad = (meth_second && alloc_default) || (abs_only && !meth_abs);
   wire [`IRQ_W-1:0] irq_evt = {(state_r == ST_MOVE) & lim_hit,
                                (state_r == ST_IDLE) & start_any & start_bad,
                                state_r == ST_DONE};
   always @(posedge i_sys_clk)
   begin
      go_r                <= 1'b0;
      abort_r             <= 1'b0;
      o_amp_zero_position <= 1'b0;
      o_deviation_clear   <= 1'b0;
      if (i_srst)
      begin
         state_r      <= ST_IDLE;
         start_d_r    <= 1'b0;
         ctrl_r       <= 5'h00;
         method_r     <= `METH_DOG1;
         offset_r     <= {POS_W{1'b0}};
         err_code_r   <= 16'h0000;
         irq_stat_r   <= {`IRQ_W{1'b0}};
         irq_mask_r   <= {`IRQ_W{1'b0}};
         seek_r       <= 1'b0;
         seek_fwd_r   <= 1'b0;
         o_axis1_busy_contact         <= 1'b0;
         o_axis1_home_done_contact    <= 1'b0;
         o_axis1_servo_locked_contact <= 1'b0;
         o_error_notify_contact       <= 1'b0;
         alloc_r[0] <= `ALLOC_A_IN1;
         alloc_r[1] <= `ALLOC_A_IN2;
         alloc_r[2] <= `ALLOC_A_IN3;
         alloc_r[3] <= `ALLOC_A_IN4;
         alloc_r[4] <= `ALLOC_A_IN5;
         alloc_r[5] <= `ALLOC_A_IN6;
         alloc_r[6] <= `ALLOC_A_IN7;
         alloc_r[7] <= `ALLOC_A_IN8;
      end
      else
      begin
         start_d_r <= start_s;
         if (son_s)
            o_axis1_servo_locked_contact <= 1'b1;
         else if (soff_s)
            o_axis1_servo_locked_contact <= 1'b0;
         if (wr && i_avs_address == `REG_CTRL)
         begin
            ctrl_r            <= i_avs_writedata[4:0];
            o_deviation_clear <= i_avs_writedata[`CTRL_DEVCLR_BIT];
         end
         if (wr && i_avs_address == `REG_METHOD)
            method_r <= i_avs_writedata[3:0];
         if (wr && i_avs_address == `REG_IRQ_MASK)
            irq_mask_r <= i_avs_writedata[`IRQ_W-1:0];
         if (wr && alloc_hit && i_avs_address[7:5] == 3'b001)
            alloc_r[alloc_idx] <= i_avs_writedata;
         case (state_r)
            ST_IDLE:
            begin
               // Start with limit already active is accepted
               if (start_pulse || (wr && i_avs_address == `REG_CTRL
                                   && i_avs_writedata[`CTRL_START_BIT]))
               begin
                  if (meth_second && alloc_default)
                  begin
                     err_code_r             <= `ERR_LATCH_ALLOC;
                     o_error_notify_contact <= 1'b1;
                  end
                  else if (abs_only && !meth_abs)
                  begin
                     err_code_r             <= `ERR_NOT_ALLOWED;
                     o_error_notify_contact <= 1'b1;
                  end
                  else
                  begin
                     o_axis1_busy_contact      <= 1'b1;
                     o_axis1_home_done_contact <= 1'b0;
                     o_error_notify_contact    <= 1'b0;
                     if (method_r == `METH_ABS_SET || method_r == `METH_DATA_SET)
                        state_r <= ST_SET;
                     else
                     begin
                        go_r       <= 1'b1;
                        seek_r     <= (method_r != `METH_HIGHSPEED);
                        seek_fwd_r <= ctrl_r[`CTRL_DIR_BIT];
                        state_r    <= ST_MOVE;
                     end
                  end
               end
            end
            ST_MOVE:
            begin
               if (lim_hit)
               begin
                  go_r                  <= 1'b1;
                  seek_fwd_r            <= ~o_move_fwd;
               end
               else if (seek_r && home_s && moving)
                  abort_r <= 1'b1;
               if (arrived)
                  state_r <= ST_DONE;  // Deviation counter left alone
            end
            ST_SET:
            begin
               if (method_r == `METH_DATA_SET && ctrl_r[`CTRL_NEWAMP_BIT])
               begin
                  o_amp_zero_position <= 1'b1;
                  offset_r            <= {POS_W{1'b0}};
               end
               else
                  offset_r <= i_amp_position;
               state_r <= ST_DONE;
            end
            ST_DONE:
            begin
               o_axis1_busy_contact      <= 1'b0;
               o_axis1_home_done_contact <= 1'b1;
               state_r                   <= ST_IDLE;
            end
            default:
               state_r <= ST_IDLE;
         endcase
         // Set wins over write-one-to-clear
         if (wr && i_avs_address == `REG_IRQ_STAT)
            irq_stat_r <= (irq_stat_r & ~i_avs_writedata[`IRQ_W-1:0]) | irq_evt;
         else
            irq_stat_r <= irq_stat_r | irq_evt;
      end
   end
   // ----------------------------------------
   // Read wait state
   // ----------------------------------------
   // One wait state per read, so read data stand when waitrequest is low
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
         rd_ack_r <= 1'b0;
      else
         rd_ack_r <= i_avs_read & ~rd_ack_r;
   end
   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_avs_readdata <= 32'h0000_0000;
      else if (i_avs_read)
      begin
         case (i_avs_address)
            `REG_CTRL:     o_avs_readdata <= {27'h0, ctrl_r};
            `REG_METHOD:   o_avs_readdata <= {28'h0, method_r};
            `REG_STATUS:   o_avs_readdata <= {err_code_r, 12'h0, state_r};
            `REG_IRQ_STAT: o_avs_readdata <= {29'h0, irq_stat_r};
            `REG_IRQ_MASK: o_avs_readdata <= {29'h0, irq_mask_r};
            `REG_CUR_POS:  o_avs_readdata <= i_amp_position;
            `REG_DISP_POS: o_avs_readdata <= disp_pos;
            `REG_OFFSET:   o_avs_readdata <= offset_r;
            `REG_FLAGS:    o_avs_readdata <= {28'h0, o_error_notify_contact,
                                              o_axis1_servo_locked_contact,
                                              o_axis1_home_done_contact,
                                              o_axis1_busy_contact};
            default:
               o_avs_readdata <= alloc_hit && i_avs_address[7:5] == 3'b001 ?
                                 alloc_r[alloc_idx] : 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: verif/home_return_sequencer_properties.sv */
`default_nettype none
// ----
// Sequencer port checker
// ----
module home_return_sequencer_properties #(
   parameter POS_W = 32
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Watched ports
   input wire logic i_axis1_home_start_request,
   input wire logic i_positive_overtravel_limit,
   input wire logic i_negative_overtravel_limit,
   input wire logic o_axis1_busy_contact,
   input wire logic o_axis1_home_done_contact,
   input wire logic o_error_notify_contact,
   input wire logic o_amp_zero_position,
   input wire logic o_deviation_clear,
   input wire logic o_move_active,
   input wire logic o_move_fwd
);
   timeunit 1ns;
   timeprecision 1ns;
   wire b  = o_axis1_busy_contact;
   wire d  = o_axis1_home_done_contact;
   wire mv = o_move_active;
   wire fw = o_move_fwd;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);
   a_flags_apart: assert property (!(b && d))
      else $error("busy and done both high");
   a_done_holds: assert property ($fell(d) |-> b)
      else $error("done dropped without a new start");
   a_done_at_end: assert property ($rose(d) |-> $fell(b))
      else $error("done rose while busy did not fall");
   a_start_taken: assert property ($rose(i_axis1_home_start_request) && !b
      |-> ##[1:5] (b || o_error_notify_contact)) else $error("start not answered");
   a_move_in_busy: assert property ($rose(mv) |-> b)
      else $error("motion began outside an operation");
   a_zero_single: assert property (o_amp_zero_position |=> !o_amp_zero_position)
      else $error("zero pulse longer than one cycle");
   a_no_dev_clear: assert property ($rose(d) |-> !o_deviation_clear)
      else $error("deviation cleared at completion");
   a_rev_forward: assert property ((mv && fw && i_positive_overtravel_limit) [*4]
      |-> ##[0:4] !(mv && fw)) else $error("no reversal at positive limit");
   a_rev_reverse: assert property ((mv && !fw && i_negative_overtravel_limit) [*4]
      |-> ##[0:4] !(mv && !fw)) else $error("no reversal at negative limit");
   cover property ($rose(d));
   cover property ($rose(o_error_notify_contact));
   cover property (mv && !fw);
endmodule
bind home_return_sequencer home_return_sequencer_properties #(.POS_W(POS_W)) props_i (
   .i_sys_clk(i_sys_clk), .i_srst(i_srst),
   .i_axis1_home_start_request(i_axis1_home_start_request),
   .i_positive_overtravel_limit(i_positive_overtravel_limit),
   .i_negative_overtravel_limit(i_negative_overtravel_limit),
   .o_axis1_busy_contact(o_axis1_busy_contact),
   .o_axis1_home_done_contact(o_axis1_home_done_contact),
   .o_error_notify_contact(o_error_notify_contact),
   .o_amp_zero_position(o_amp_zero_position), .o_deviation_clear(o_deviation_clear),
   .o_move_active(o_move_active), .o_move_fwd(o_move_fwd)
);
`default_nettype wire

/* File: verif/amp_model.sv */
`default_nettype none
// ----
// Slow amplifier: one step every fourth cycle
// ----
module amp_model (
   // Clock
   input wire logic        i_clk,
   // Commands from the sequencer
   input wire logic        i_move,
   input wire logic        i_fwd,
   input wire logic        i_zero,
   // Bench preset
   input wire logic        i_load,
   input wire logic [31:0] i_load_val,
   // Feedback
   output var logic [31:0] o_pos
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div_r = 2'h0;
   always @(posedge i_clk)
   begin
      div_r <= div_r + 2'h1;
      if (i_load)
         o_pos <= i_load_val;
      else if (i_zero)
         o_pos <= 32'h0;
      else if (i_move && div_r == 2'h3)
         o_pos <= i_fwd ? o_pos + 32'h1 : o_pos - 32'h1;
   end
endmodule
`default_nettype wire

/* File: verif/tb_home_return_sequencer.sv */
`default_nettype none
`include "home_return_map.vh"
module tb_home_return_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, srst, rd, wr, sreq, son, soff, pl, nl, nh, ld, seen_dc, seen_zp;
   logic [7:0]  adr;
   logic [31:0] wd, lv, rdv;
   wire  [31:0] rdata, apos;
   wire         wreq, bsy, dn, lck, er, zp, dc, mv, fwd, irq;
   int          errors, checks, i;
   home_return_sequencer home_return_sequencer_i (
      .i_sys_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_axis1_home_start_request(sreq),
      .i_axis1_servo_on_request(son), .i_axis1_servo_off_request(soff),
      .o_axis1_busy_contact(bsy), .o_axis1_home_done_contact(dn),
      .o_axis1_servo_locked_contact(lck), .o_error_notify_contact(er),
      .i_amp_position(apos), .i_positive_overtravel_limit(pl),
      .i_negative_overtravel_limit(nl), .i_near_home_sensor(nh),
      .o_amp_zero_position(zp), .o_deviation_clear(dc), .o_move_active(mv),
      .o_move_fwd(fwd), .o_irq(irq));
   amp_model amp_model_i (.i_clk(clk), .i_move(mv), .i_fwd(fwd), .i_zero(zp),
      .i_load(ld), .i_load_val(lv), .o_pos(apos));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (srst)
      begin
         seen_dc <= 1'b0;
         seen_zp <= 1'b0;
      end
      else
      begin
         if (dc === 1'b1) seen_dc <= 1'b1;
         if (zp === 1'b1) seen_zp <= 1'b1;
      end
   end
   task automatic end_of_test;
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // ----
   // Bus access: hold until waitrequest is seen low, take data at that edge
   // ----
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 100);
      if (n >= 100) begin errors++; end_of_test; end
      rdv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic go;
      @(posedge clk);
      sreq <= 1'b1;
      @(posedge clk);
      sreq <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic load(input logic [31:0] v);
      @(posedge clk);
      ld <= 1'b1;
      lv <= v;
      @(posedge clk);
      ld <= 1'b0;
   endtask
   task automatic wt(input int k);
      int n;
      n = 0;
      while (!((k == 0 && dn === 1'b1) || (k == 1 && mv === 1'b1 && fwd === 1'b0)
         || (k == 2 && mv === 1'b1 && fwd === 1'b1)) && n < 3000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 3000) begin errors++; end_of_test; end
   endtask
   initial
   begin
      {rd, wr, sreq, son, soff, pl, nl, nh} = 8'h00;
      adr = 8'h00;
      wd = 32'h0;
      lv = 32'h0;
      ld = 1'b1;
      srst = 1'b1;
      errors = 0;
      checks = 0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      ld <= 1'b0;
      son <= 1'b1;
      @(posedge clk);
      son <= 1'b0;
      #1 cmp(dn, 1'b0);
      bus(0, 8'h24, 32'h0); cmp(rdv, `ALLOC_A_IN2);
      cmp(lck, 1'b1);
      bus(0, 8'h28, 32'h0); cmp(rdv, `ALLOC_A_IN3);
      bus(0, 8'h34, 32'h0); cmp(rdv, `ALLOC_A_IN6);
      for (i = 0; i < 3; i++)
      begin
         bus(1, `REG_METHOD, i);
         bus(1, `REG_CTRL, i == 0 ? 32'h4 : 32'h0);
         go;
         cmp(bsy, 1'b0);
         cmp(er, 1'b1);
         bus(0, `REG_STATUS, 32'h0);
         cmp(rdv[31:16], i == 0 ? `ERR_NOT_ALLOWED : `ERR_LATCH_ALLOC);
      end
      load(32'h14);
      bus(1, `REG_METHOD, `METH_HIGHSPEED);
      bus(1, `REG_CTRL, 32'h4);
      go;
      cmp(bsy, 1'b1);
      wt(0);
      cmp(bsy, 1'b0);
      bus(0, `REG_CUR_POS, 32'h0); cmp(rdv, 32'h0);
      cmp(seen_dc, 1'b0);
      bus(1, `REG_IRQ_MASK, 32'h1);
      cmp(irq, 1'b1);
      bus(1, `REG_IRQ_STAT, 32'h1);
      cmp(irq, 1'b0);
      bus(1, `REG_CTRL, 32'h6);
      load(32'h3E8);
      cmp(seen_dc, 1'b1);
      bus(1, `REG_METHOD, `METH_ABS_SET);
      go;
      cmp(dn, 1'b0);
      wt(0);
      bus(0, `REG_OFFSET, 32'h0); cmp(rdv, 32'h3E8);
      bus(0, `REG_DISP_POS, 32'h0); cmp(rdv, 32'h0);
      bus(0, `REG_CUR_POS, 32'h0); cmp(rdv, 32'h3E8);
      cmp(seen_zp, 1'b0);
      load(32'h3F2);
      bus(0, `REG_DISP_POS, 32'h0); cmp(rdv, 32'hA);
      bus(1, `REG_CTRL, 32'hC);
      bus(1, `REG_METHOD, `METH_DATA_SET);
      go;
      wt(0);
      cmp(seen_zp, 1'b1);
      bus(0, `REG_CUR_POS, 32'h0); cmp(rdv, 32'h0);
      bus(1, 8'h24, `ALLOC_B_IN2);
      bus(1, 8'h28, `ALLOC_B_IN2);
      bus(1, 8'h34, `ALLOC_B_IN6);
      bus(1, 8'h38, `ALLOC_B_IN7);
      bus(1, `REG_CTRL, 32'h10);
      bus(1, `REG_METHOD, `METH_DOG2);
      load(32'h64);
      nl <= 1'b1;
      go;
      cmp(bsy, 1'b1);
      @(posedge clk);
      nl <= 1'b0;
      pl <= 1'b1;
      wt(1);
      @(posedge clk);
      pl <= 1'b0;
      nl <= 1'b1;
      wt(2);
      @(posedge clk);
      nl <= 1'b0;
      nh <= 1'b1;
      wt(0);
      cmp(bsy, 1'b0);
      @(posedge clk);
      soff <= 1'b1;
      @(posedge clk);
      soff <= 1'b0;
      repeat (3) @(posedge clk);
      #1 cmp(lck, 1'b0);
      end_of_test;
   end
endmodule
`default_nettype wire
